// ---- logic/arith_prefix_pkg.sv ----
// arith_prefix_pkg: opcode patterns, clock counts, states and carriers for the decoder
// assumes one clock domain; bytes arrive from logic on the same clock
`default_nettype none
package arith_prefix_pkg;
    // opcode bytes and patterns
    localparam logic [7:0] code_segment_prefix     = 8'h2E;
    localparam logic [7:0] stack_segment_prefix    = 8'h36;
    localparam logic [7:0] data_segment_prefix     = 8'h3E;
    localparam logic [7:0] extra_segment_prefix    = 8'h26;
    localparam logic [7:0] ascii_adjust_after_add  = 8'h37;
    localparam logic [7:0] decimal_adjust_after_add = 8'h27;
    localparam logic [7:0] ascii_adjust_after_sub  = 8'h3F;
    localparam logic [7:0] decimal_adjust_after_sub = 8'h2F;
    localparam logic [1:0] mod_register            = 2'h3;
    // reg field selectors inside the immediate and unary groups
    localparam logic [2:0] sel_add                 = 3'h0;
    localparam logic [2:0] sel_add_carry           = 3'h2;
    localparam logic [2:0] sel_sub_borrow          = 3'h3;
    localparam logic [2:0] sel_sub                 = 3'h5;
    localparam logic [2:0] sel_compare             = 3'h7;
    localparam logic [2:0] sel_inc                 = 3'h0;
    localparam logic [2:0] sel_dec                 = 3'h1;
    localparam logic [2:0] sel_negate              = 3'h3;
    localparam logic [2:0] sel_multiply            = 3'h4;
    // minimum clock counts, with maximum counts for multiply
    localparam logic [5:0] clk_prefix              = 6'h02;
    localparam logic [5:0] clk_alu_reg             = 6'h03;
    localparam logic [5:0] clk_alu_mem             = 6'h0A;
    localparam logic [5:0] clk_imm_reg             = 6'h04;
    localparam logic [5:0] clk_imm_mem             = 6'h10;
    localparam logic [5:0] clk_acc_byte            = 6'h03;
    localparam logic [5:0] clk_acc_word            = 6'h04;
    localparam logic [5:0] clk_incdec_mem          = 6'h0F;
    localparam logic [5:0] clk_ascii_add           = 6'h08;
    localparam logic [5:0] clk_decimal_adj         = 6'h04;
    localparam logic [5:0] clk_ascii_sub           = 6'h07;
    localparam logic [5:0] clk_mul_rb_min          = 6'h1A;
    localparam logic [5:0] clk_mul_rb_max          = 6'h1C;
    localparam logic [5:0] clk_mul_rw_min          = 6'h23;
    localparam logic [5:0] clk_mul_rw_max          = 6'h25;
    localparam logic [5:0] clk_mul_mb_min          = 6'h20;
    localparam logic [5:0] clk_mul_mb_max          = 6'h22;
    localparam logic [5:0] clk_mul_mw_min          = 6'h29;
    localparam logic [5:0] clk_mul_mw_max          = 6'h2B;
    localparam logic [5:0] clk_one                 = 6'h01;
    localparam logic [5:0] clk_none                = 6'h00;

    typedef enum logic [2:0] {
        st_opcode = 3'h0,
        st_modrm  = 3'h1,
        st_imm_lo = 3'h2,
        st_imm_hi = 3'h3,
        st_exec   = 3'h4
    } state_type;

    typedef enum logic [3:0] {
        op_none                  = 4'h0,
        op_segment_prefix        = 4'h1,
        op_add                   = 4'h2,
        op_add_with_carry        = 4'h3,
        op_subtract              = 4'h4,
        op_subtract_with_borrow  = 4'h5,
        op_increment             = 4'h6,
        op_decrement             = 4'h7,
        op_compare               = 4'h8,
        op_negate                = 4'h9,
        op_ascii_add             = 4'hA,
        op_decimal_add           = 4'hB,
        op_ascii_sub             = 4'hC,
        op_decimal_sub           = 4'hD,
        op_unsigned_multiply     = 4'hE,
        op_unsupported           = 4'hF
    } op_type;

    typedef enum logic [2:0] {
        form_single  = 3'h0,
        form_modrm   = 3'h1,
        form_acc_imm = 3'h2,
        form_grp_imm = 3'h3,
        form_grp_f6  = 3'h4,
        form_grp_fe  = 3'h5,
        form_reg     = 3'h6
    } form_type;

    // segment encoding: 0 extra, 1 code, 2 stack, 3 data
    typedef struct packed {
        op_type      op;
        form_type    form;
        logic        w;
        logic        d;
        logic        s;
        logic        mem;
        logic [1:0]  mod_field;
        logic [2:0]  reg_field;
        logic [2:0]  rm_field;
        logic [15:0] imm;
        logic        seg_override;
        logic [1:0]  seg;
        logic [5:0]  clk_min;
        logic [5:0]  clk_max;
    } result_type;

    typedef struct packed {
        state_type   st;
        result_type  cur;
        result_type  res;
        logic        done;
        logic        seg_pend;
        logic [1:0]  seg_pend_sel;
        logic [5:0]  count;
    } core_type;
endpackage
`default_nettype wire

// ---- logic/arith_prefix_decoder.sv ----
// arith_prefix_decoder: decodes segment prefixes and the integer arithmetic group, then
// holds off the byte stream for the minimum execution clocks of each instruction
// assumes the byte source is logic on clk_i and holds a byte until byte_ready_o
`default_nettype none
module arith_prefix_decoder
    import arith_prefix_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        byte_valid_i,
    input  wire logic [7:0]  byte_i,
    output logic             byte_ready_o,
    output logic             done_o,
    output var result_type   result_o
);

    core_type state;
    core_type next_state;

    // opcode byte to operation and form
    function automatic result_type decode_opcode(input logic [7:0] b);
        result_type r;
        r = '0;
        r.op = op_unsupported;
        r.form = form_single;
        r.w = b[0];
        r.d = b[1];
        casez (b)
            code_segment_prefix, stack_segment_prefix,
            data_segment_prefix, extra_segment_prefix: begin
                r.op = op_segment_prefix;
                r.seg_override = 1'b1;
                r.seg = b[4:3];
            end
            8'b000000??: begin r.op = op_add; r.form = form_modrm; end
            8'b0000010?: begin r.op = op_add; r.form = form_acc_imm; end
            8'b000100??: begin r.op = op_add_with_carry; r.form = form_modrm; end
            8'b0001010?: begin r.op = op_add_with_carry; r.form = form_acc_imm; end
            8'b001010??: begin r.op = op_subtract; r.form = form_modrm; end
            8'b0010110?: begin r.op = op_subtract; r.form = form_acc_imm; end
            8'b000110??: begin
                r.op = op_subtract_with_borrow;
                r.form = form_modrm;
            end
            8'b0001110?: begin
                r.op = op_subtract_with_borrow;
                r.form = form_acc_imm;
            end
            8'b0011100?, 8'b0011101?: begin r.op = op_compare; r.form = form_modrm; end
            8'b0011110?: begin r.op = op_compare; r.form = form_acc_imm; end
            8'b100000??: begin r.op = op_none; r.form = form_grp_imm; r.s = b[1]; r.d = 1'b0; end
            8'b1111011?: begin r.op = op_none; r.form = form_grp_f6; r.d = 1'b0; end
            8'b1111111?: begin r.op = op_none; r.form = form_grp_fe; r.d = 1'b0; end
            8'b01000???: begin
                r.op = op_increment;
                r.form = form_reg;
                r.w = 1'b1;
                r.reg_field = b[2:0];
            end
            8'b01001???: begin
                r.op = op_decrement;
                r.form = form_reg;
                r.w = 1'b1;
                r.reg_field = b[2:0];
            end
            ascii_adjust_after_add:   r.op = op_ascii_add;
            decimal_adjust_after_add: r.op = op_decimal_add;
            ascii_adjust_after_sub:   r.op = op_ascii_sub;
            decimal_adjust_after_sub: r.op = op_decimal_sub;
            default: r.op = op_unsupported;
        endcase
        return r;
    endfunction

    // group operation chosen by the reg field of the operand byte
    function automatic op_type group_op(input form_type f, input logic w, input logic [2:0] sel);
        op_type o;
        o = op_unsupported;
        case (f)
            form_grp_imm: begin
                case (sel)
                    sel_add:        o = op_add;
                    sel_add_carry:  o = op_add_with_carry;
                    sel_sub:        o = op_subtract;
                    sel_sub_borrow: o = op_subtract_with_borrow;
                    sel_compare:    o = op_compare;
                    default:        o = op_unsupported;
                endcase
            end
            form_grp_f6: begin
                case (sel)
                    sel_negate:   o = op_negate;
                    sel_multiply: o = op_unsigned_multiply;
                    default:      o = op_unsupported;
                endcase
            end
            form_grp_fe: begin
                if (sel == sel_inc) begin
                    o = op_increment;
                end else if (sel == sel_dec) begin
                    o = op_decrement;
                end else begin
                    o = op_unsupported;
                end
                if (!w && sel != sel_inc && sel != sel_dec) begin
                    o = op_unsupported;
                end
            end
            default: o = op_unsupported;
        endcase
        return o;
    endfunction

    // minimum and maximum clock counts of a decoded instruction
    function automatic logic [11:0] clocks(input result_type r);
        logic [5:0] lo;
        lo = clk_one;
        case (r.op)
            op_segment_prefix: lo = clk_prefix;
            op_ascii_add:      lo = clk_ascii_add;
            op_decimal_add:    lo = clk_decimal_adj;
            op_ascii_sub:      lo = clk_ascii_sub;
            op_decimal_sub:    lo = clk_decimal_adj;
            op_unsigned_multiply: begin
                case ({r.mem, r.w})
                    2'h0:    return {clk_mul_rb_min, clk_mul_rb_max};
                    2'h1:    return {clk_mul_rw_min, clk_mul_rw_max};
                    2'h2:    return {clk_mul_mb_min, clk_mul_mb_max};
                    default: return {clk_mul_mw_min, clk_mul_mw_max};
                endcase
            end
            op_unsupported, op_none: lo = clk_one;
            default: begin
                case (r.form)
                    form_acc_imm: lo = r.w ? clk_acc_word : clk_acc_byte;
                    form_reg:     lo = clk_alu_reg;
                    form_grp_fe:  lo = r.mem ? clk_incdec_mem : clk_alu_reg;
                    form_grp_imm: begin
                        if (r.op == op_compare) begin
                            lo = r.mem ? clk_alu_mem : clk_alu_reg;
                        end else begin
                            lo = r.mem ? clk_imm_mem : clk_imm_reg;
                        end
                    end
                    default: lo = r.mem ? clk_alu_mem : clk_alu_reg;
                endcase
            end
        endcase
        return {lo, lo};
    endfunction

    // load the timing of the collected instruction and enter execution
    function automatic core_type start_exec(input core_type c);
        core_type n;
        logic [11:0] t;
        n = c;
        t = clocks(c.cur);
        n.cur.clk_min = t[11:6];
        n.cur.clk_max = t[5:0];
        if (c.cur.op != op_segment_prefix) begin
            n.cur.seg_override = c.seg_pend;
            n.cur.seg = c.seg_pend_sel;
        end
        n.count = t[11:6] - clk_one;
        n.st = st_exec;
        return n;
    endfunction

    always_comb begin
        next_state = state;
        next_state.done = 1'b0;
        byte_ready_o = (state.st != st_exec);
        case (state.st)
            st_opcode: begin
                if (byte_valid_i) begin
                    next_state.cur = decode_opcode(byte_i);
                    case (next_state.cur.form)
                        form_acc_imm: next_state.st = st_imm_lo;
                        form_single, form_reg: next_state = start_exec(next_state);
                        default: next_state.st = st_modrm;
                    endcase
                end
            end
            st_modrm: begin
                if (byte_valid_i) begin
                    next_state.cur.mod_field = byte_i[7:6];
                    next_state.cur.reg_field = byte_i[5:3];
                    next_state.cur.rm_field = byte_i[2:0];
                    next_state.cur.mem = (byte_i[7:6] != mod_register);
                    if (state.cur.form != form_modrm) begin
                        next_state.cur.op = group_op(state.cur.form, state.cur.w, byte_i[5:3]);
                    end
                    if (state.cur.form == form_grp_imm &&
                        next_state.cur.op != op_unsupported) begin
                        next_state.st = st_imm_lo;
                    end else begin
                        next_state = start_exec(next_state);
                    end
                end
            end
            st_imm_lo: begin
                if (byte_valid_i) begin
                    next_state.cur.imm = {(state.cur.s ? {8{byte_i[7]}} : 8'h00), byte_i};
                    if (state.cur.form == form_acc_imm ? state.cur.w
                        : ({state.cur.s, state.cur.w} == 2'h1)) begin
                        next_state.st = st_imm_hi;
                    end else begin
                        next_state = start_exec(next_state);
                    end
                end
            end
            st_imm_hi: begin
                if (byte_valid_i) begin
                    next_state.cur.imm[15:8] = byte_i;
                    next_state = start_exec(next_state);
                end
            end
            st_exec: begin
                if (state.count == clk_none) begin
                    next_state.done = 1'b1;
                    next_state.res = state.cur;
                    next_state.st = st_opcode;
                    if (state.cur.op == op_segment_prefix) begin
                        next_state.seg_pend = 1'b1;
                        next_state.seg_pend_sel = state.cur.seg;
                    end else begin
                        next_state.seg_pend = 1'b0;
                    end
                end else begin
                    next_state.count = state.count - clk_one;
                end
            end
            default: next_state.st = st_opcode;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign done_o = state.done;
    assign result_o = state.res;

endmodule // arith_prefix_decoder
`default_nettype wire

// ---- tb/arith_prefix_props.sv ----
// arith_prefix_props: port checker for arith_prefix_decoder
// assumes one clock, clk_i rising edge, rst_i synchronous active high
`default_nettype none
module arith_prefix_props
    import arith_prefix_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       byte_valid_i,
    input wire logic [7:0] byte_i,
    input wire logic       byte_ready_o,
    input wire logic       done_o,
    input wire result_type result_o
);
    logic [5:0] low_cnt;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // counts execution cycles with the byte stream held off
    always_ff @(posedge clk_i) begin
        if (rst_i || byte_ready_o) begin
            low_cnt <= 6'h00;
        end else begin
            low_cnt <= low_cnt + 6'h01;
        end
    end
    a_stall_count: assert property (
        done_o |-> low_cnt == result_o.clk_min) else $error("stall length differs from clk_min");
    a_done_pulse: assert property (
        done_o |=> !done_o) else $error("done longer than one cycle");
    a_done_ready: assert property (
        done_o |-> byte_ready_o && $past(!byte_ready_o)) else $error("done without stall");
    a_prefix_clk: assert property (
        done_o && result_o.op == op_segment_prefix |-> result_o.clk_min == 6'h02
        && result_o.clk_max == 6'h02) else $error("prefix clocks wrong");
    a_acc_clk: assert property (
        done_o && result_o.form == form_acc_imm |-> result_o.clk_min == (result_o.w ? 6'h04
        : 6'h03)) else $error("accumulator clocks wrong");
    a_group_clk: assert property (
        done_o && result_o.form == form_grp_imm && result_o.op != op_unsupported |->
        result_o.clk_min == (result_o.op == op_compare ? (result_o.mem ? 6'h0A : 6'h03)
        : (result_o.mem ? 6'h10 : 6'h04))) else $error("immediate group clocks wrong");
    a_negate_clk: assert property (
        done_o && result_o.op == op_negate |-> result_o.clk_min == (result_o.mem ? 6'h0A
        : 6'h03)) else $error("negate clocks wrong");
    a_mul_range: assert property (
        done_o && result_o.op == op_unsigned_multiply |-> result_o.clk_max ==
        result_o.clk_min + 6'h02 && result_o.clk_min == (result_o.mem ? (result_o.w ? 6'h29
        : 6'h20) : (result_o.w ? 6'h23 : 6'h1A))) else $error("multiply range wrong");
    a_ascii_clk: assert property (
        done_o && result_o.op inside {op_ascii_add, op_ascii_sub} |-> result_o.clk_min ==
        (result_o.op == op_ascii_add ? 6'h08 : 6'h07)) else $error("ascii adjust clocks wrong");
    a_adjust_clk: assert property (
        done_o && result_o.op inside {op_decimal_add, op_decimal_sub} |-> result_o.clk_min
        == 6'h04) else $error("decimal adjust clocks wrong");
    a_incdec_clk: assert property (
        done_o && result_o.op inside {op_increment, op_decrement} |-> result_o.clk_min ==
        (result_o.mem ? 6'h0F : 6'h03)) else $error("inc or dec clocks wrong");
    c_prefix: cover property (done_o && result_o.op == op_segment_prefix);
    c_multiply: cover property (done_o && result_o.op == op_unsigned_multiply);
    c_refused: cover property (done_o && result_o.op == op_unsupported);
    c_compare_group: cover property (done_o && result_o.op == op_compare
        && result_o.form == form_grp_imm);
endmodule // arith_prefix_props
bind arith_prefix_decoder arith_prefix_props arith_prefix_props_i (.clk_i(clk_i),
    .rst_i(rst_i), .byte_valid_i(byte_valid_i), .byte_i(byte_i),
    .byte_ready_o(byte_ready_o), .done_o(done_o), .result_o(result_o));
`default_nettype wire

// ---- tb/byte_source_model.sv ----
// byte_source_model: prefetch queue model offering bytes to the decoder
// assumes bytes change at falling edges and stay until taken at a rising edge
`default_nettype none
module byte_source_model (
    input  wire logic       clk_i,
    input  wire logic       byte_ready_i,
    input  wire logic       slow_i,
    output logic            byte_valid_o = 1'b0,
    output logic [7:0]      byte_o = 8'hA5
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] fifo [$];
    logic       taken = 1'b0;
    logic       phase = 1'b0;
    task automatic push(input logic [7:0] b);
        fifo.push_back(b);
    endtask
    always @(posedge clk_i) begin
        taken <= byte_valid_o && byte_ready_i;
    end
    always @(negedge clk_i) begin
        phase = ~phase;
        if (taken && fifo.size() > 0) begin
            void'(fifo.pop_front());
        end
        if (byte_valid_o && !taken && fifo.size() > 0) begin
            byte_o = fifo[0];
        end else if (fifo.size() > 0 && (!slow_i || phase)) begin
            byte_valid_o = 1'b1;
            byte_o = fifo[0];
        end else begin
            // idle line toggles so no stale byte is seen
            byte_valid_o = 1'b0;
            byte_o = ~byte_o;
        end
    end
endmodule // byte_source_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// tb_top: self-checking bench for arith_prefix_decoder with a byte source model
// assumes 40 MHz clock and synchronous active-high reset held 8 cycles
`default_nettype none
module tb_top
    import arith_prefix_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       slow = 1'b0;
    logic       valid;
    logic [7:0] data;
    logic       ready;
    logic       done;
    result_type result;
    int         fails = 0;
    int         comparisons = 0;
    always #12.5 clk_i = ~clk_i;
    arith_prefix_decoder arith_prefix_decoder_i (.clk_i(clk_i), .rst_i(rst_i),
        .byte_valid_i(valid), .byte_i(data), .byte_ready_o(ready), .done_o(done),
        .result_o(result));
    byte_source_model byte_source_model_i (.clk_i(clk_i), .byte_ready_i(ready),
        .slow_i(slow), .byte_valid_o(valid), .byte_o(data));
    task automatic final_report();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check_val(input logic [63:0] got, input logic [63:0] exp, input string s);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s got %0h exp %0h", $time, s, got, exp);
        end
    endtask
    task automatic check_op(input op_type got, input op_type exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t op got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic send1(input logic [7:0] b);
        byte_source_model_i.push(b);
    endtask
    task automatic send2(input logic [15:0] b);
        send1(b[15:8]);
        send1(b[7:0]);
    endtask
    task automatic expect_done(input op_type op, input logic [5:0] mn, input logic [5:0] mx);
        int n;
        n = 0;
        @(negedge clk_i);
        while (done !== 1'b1 && n < 100) begin
            @(negedge clk_i);
            n++;
        end
        check_val(64'(done), 64'h1, "done");
        check_op(result.op, op);
        check_val(64'(result.clk_min), 64'(mn), "clk_min");
        check_val(64'(result.clk_max), 64'(mx), "clk_max");
    endtask
    task automatic t_prefix();
        logic [7:0] pre [4] = '{8'h2E, 8'h36, 8'h3E, 8'h26};
        for (int i = 0; i < 4; i++) begin
            send1(pre[i]);
            send2(16'h00C1);
            expect_done(op_segment_prefix, 6'h02, 6'h02);
            expect_done(op_add, 6'h03, 6'h03);
            check_val(64'({result.seg_override, result.seg}), 64'(4 + (i + 1) % 4), "seg");
        end
        send2(16'h2E26);
        send2(16'h0412);
        send1(8'h3F);
        expect_done(op_segment_prefix, 6'h02, 6'h02);
        expect_done(op_segment_prefix, 6'h02, 6'h02);
        expect_done(op_add, 6'h03, 6'h03);
        check_val(64'({result.seg_override, result.seg}), 64'h4, "latest");
        expect_done(op_ascii_sub, 6'h07, 6'h07);
        check_val(64'(result.seg_override), 64'h0, "cleared");
        $display("test prefix done");
    endtask
    task automatic t_imm();
        send2(16'h0412);
        send2(16'h0534);
        send2(16'h1283);
        send2(16'hD085);
        send2(16'h81E8);
        send2(16'h3412);
        send2(16'h8018);
        send2(16'h7F80);
        send2(16'hC827);
        expect_done(op_add, 6'h03, 6'h03);
        check_val(64'(result.imm), 64'h0012, "imm");
        expect_done(op_add, 6'h04, 6'h04);
        check_val(64'(result.imm), 64'h1234, "imm");
        expect_done(op_add_with_carry, 6'h04, 6'h04);
        check_val(64'(result.imm), 64'hFF85, "imm");
        expect_done(op_subtract, 6'h04, 6'h04);
        check_val(64'(result.imm), 64'h1234, "imm");
        expect_done(op_subtract_with_borrow, 6'h10, 6'h10);
        check_val(64'(result.imm), 64'h007F, "imm");
        expect_done(op_unsupported, 6'h01, 6'h01);
        expect_done(op_decimal_add, 6'h04, 6'h04);
        send2(16'h1480);
        send2(16'h2D01);
        send2(16'h803C);
        send2(16'h0583);
        send2(16'hF8FE);
        send2(16'h8100);
        send2(16'hCDAB);
        send2(16'h8238);
        send2(16'h80FE);
        send1(8'h00);
        expect_done(op_add_with_carry, 6'h03, 6'h03);
        check_val(64'(result.imm), 64'h0080, "imm");
        expect_done(op_subtract, 6'h04, 6'h04);
        check_val(64'(result.imm), 64'h8001, "imm");
        expect_done(op_compare, 6'h03, 6'h03);
        check_val(64'(result.imm), 64'h0005, "imm");
        expect_done(op_compare, 6'h03, 6'h03);
        check_val(64'(result.imm), 64'hFFFE, "imm");
        check_val(64'({result.s, result.w, result.mem}), 64'h6, "sw");
        check_val(64'({result.reg_field, result.rm_field}), 64'h38, "rm");
        expect_done(op_add, 6'h10, 6'h10);
        check_val(64'(result.imm), 64'hABCD, "imm");
        expect_done(op_compare, 6'h0A, 6'h0A);
        check_val(64'(result.imm), 64'hFF80, "imm");
        expect_done(op_increment, 6'h0F, 6'h0F);
        $display("test immediate done");
    endtask
    task automatic t_table();
        logic [15:0] f [14] = '{16'h12C0, 16'h2A00, 16'h1BC0, 16'h3BC0, 16'h3807, 16'hF6D8,
            16'hF718, 16'hF6E0, 16'hF7E0, 16'hF620, 16'hF720, 16'hFEC0, 16'hFF08, 16'hFED0};
        op_type o [14] = '{op_add_with_carry, op_subtract, op_subtract_with_borrow,
            op_compare, op_compare, op_negate, op_negate, op_unsigned_multiply,
            op_unsigned_multiply, op_unsigned_multiply, op_unsigned_multiply, op_increment,
            op_decrement, op_unsupported};
        logic [5:0] mn [14] = '{3, 10, 3, 3, 10, 3, 10, 26, 35, 32, 41, 3, 15, 1};
        logic [5:0] mx [14] = '{3, 10, 3, 3, 10, 3, 10, 28, 37, 34, 43, 3, 15, 1};
        slow = 1'b1;
        for (int i = 0; i < 14; i++) begin
            send2(f[i]);
        end
        for (int i = 0; i < 14; i++) begin
            expect_done(o[i], mn[i], mx[i]);
        end
        slow = 1'b0;
        $display("test table done");
    endtask
    task automatic t_single();
        logic [7:0] b [7] = '{8'h37, 8'h27, 8'h3F, 8'h2F, 8'h40, 8'h4B, 8'h1C};
        op_type o [7] = '{op_ascii_add, op_decimal_add, op_ascii_sub, op_decimal_sub,
            op_increment, op_decrement, op_subtract_with_borrow};
        logic [5:0] c [7] = '{8, 4, 7, 4, 3, 3, 3};
        for (int i = 0; i < 7; i++) begin
            send1(b[i]);
        end
        send1(8'h55);
        for (int i = 0; i < 7; i++) begin
            expect_done(o[i], c[i], c[i]);
        end
        check_val(64'(result.imm), 64'h0055, "imm");
        $display("test single done");
    endtask
    task automatic t_reset();
        send2(16'hF7E0);
        repeat (10) @(negedge clk_i);
        rst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        rst_i = 1'b0;
        check_val(64'({ready, done}), 64'h2, "reset ready");
        check_val(64'(result), 64'h0, "reset result");
        send1(8'h37);
        expect_done(op_ascii_add, 6'h08, 6'h08);
        $display("test reset done");
    endtask
    initial begin
        repeat (8) @(negedge clk_i);
        rst_i = 1'b0;
        t_prefix();
        t_imm();
        t_table();
        t_single();
        t_reset();
        final_report();
    end
    initial begin
        #125000;
        fails++;
        final_report();
    end
endmodule // tb_top
`default_nettype wire
